// [src/qec_counter.sv]
// Quadrature encoder position counter with APB register access
`timescale 1ns/1ps
module qec_counter
	import qec_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        phase_a_pin,
	input  wire logic        phase_b_pin,
	input  wire logic        index_marker_pin,
	input  wire logic        strobe_marker_pin,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [3:0]  sy1;     // First sync stage, read only by sy2
		logic [3:0]  sy2;
		logic [3:0]  last;    // Previous synchronised sample
		logic [1:0]  stab;    // Stable sample counter
		logic [5:0]  div;     // Filter clock divider
		logic [3:0]  filt;    // Filtered A,B,Z,S
		logic [15:0] ctrl;
		logic [15:0] maxc;
		logic [5:0]  fdiv;
		logic        unini;
		logic [15:0] cnt;
		logic        dir;
		logic        zarm;    // Marker seen, reset pending
		logic        carm;    // Marker seen, capture pending
		logic        found;
		logic        algn_ok;
		logic [1:0]  algn;    // Edge of first reset: {is_b, level}
		logic [15:0] zcap;
		logic [15:0] scap;
		logic [31:0] rdat;
		logic        rdy;
		logic        err;
	} qec_state_t;

	qec_state_t st_ff;
	qec_state_t nxt_st;

	// Wrap to other end of the range
	function automatic logic [15:0] step(input logic [15:0] v, input logic up, input logic [15:0] m);
		if (up)
			step = (v == m) ? 16'h0000 : v + 16'h0001;
		else
			step = (v == 16'h0000) ? m : v - 16'h0001;
	endfunction

	// Address decode used by both read and write paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_CONTROL) || (a == OFS_STATUS) || (a == OFS_COUNT) || (a == OFS_MAXCNT)
			|| (a == OFS_ZCAP) || (a == OFS_SCAP) || (a == OFS_FILTER);
	endfunction

	logic [3:0]  raw;
	logic        qa;
	logic        qb;
	logic        pa;
	logic        pb;
	logic        pulse;
	logic        up;
	logic        z_rise;
	logic        z_fall;
	logic        s_rise;
	logic        s_fall;
	logic        z_mark;
	logic        b_edge;
	logic        fire;
	logic        access;
	logic [15:0] stat;
	logic [3:0]  nf;

	assign raw = {strobe_marker_pin, index_marker_pin, phase_b_pin, phase_a_pin};

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		nxt_st = st_ff;
		// Two-stage synchroniser, then a divided-clock four-sample filter
		nxt_st.sy1 = raw;
		nxt_st.sy2 = st_ff.sy1;
		if (st_ff.div >= st_ff.fdiv)
		begin
			nxt_st.div  = 6'h00;
			nxt_st.last = st_ff.sy2;
			if (st_ff.sy2 != st_ff.last)
				nxt_st.stab = 2'h0;
			else if (st_ff.stab != FILT_STABLE)
				nxt_st.stab = st_ff.stab + 2'h1;
			else
				nxt_st.filt = st_ff.sy2;
		end
		else
			nxt_st.div = st_ff.div + 6'h01;

		// Input swap; filtered copies used for edge detection
		// Taken from the local copy so no loop runs through a module-level net
		nf = nxt_st.filt;
		qa = st_ff.ctrl[CTL_SWAP] ? nf[1] : nf[0];
		qb = st_ff.ctrl[CTL_SWAP] ? nf[0] : nf[1];
		pa = st_ff.ctrl[CTL_SWAP] ? st_ff.filt[1] : st_ff.filt[0];
		pb = st_ff.ctrl[CTL_SWAP] ? st_ff.filt[0] : st_ff.filt[1];
		z_rise = nf[2] & ~st_ff.filt[2];
		z_fall = ~nf[2] & st_ff.filt[2];
		s_rise = nf[3] & ~st_ff.filt[3];
		s_fall = ~nf[3] & st_ff.filt[3];

		if (st_ff.ctrl[CTL_FDM])
		begin
			// Pulse train on A, direction on B (pin level)
			pulse = nf[0] ^ st_ff.filt[0];
			up    = ~nf[1];
		end
		else
		begin
			// Exactly one of A,B changed; both together is invalid
			pulse = (qa ^ pa) ^ (qb ^ pb);
			up    = (qa ^ pa) ? (qa != qb) : (qa == qb);
		end
		b_edge = qb ^ pb;

		// Marker recognised on direction-matched edge
		z_mark = st_ff.dir ? z_rise : z_fall;
		access = psel & penable & ~st_ff.rdy;
		fire   = 1'b0;

		if (pulse)
		begin
			nxt_st.dir = up;
			nxt_st.cnt = step(st_ff.cnt, up, st_ff.maxc);
			// Pending index reset uses recorded edge once aligned
			if (st_ff.zarm && (!st_ff.algn_ok || (st_ff.algn == {b_edge, up ? qb : ~qb})))
				fire = 1'b1;
			if (st_ff.carm)
			begin
				nxt_st.zcap = st_ff.cnt;
				nxt_st.carm = 1'b0;
			end
		end
		if (fire)
		begin
			nxt_st.cnt  = up ? 16'h0000 : st_ff.maxc;
			nxt_st.zarm = 1'b0;
			if (!st_ff.algn_ok)
			begin
				nxt_st.algn_ok = 1'b1;
				nxt_st.algn    = {b_edge, up ? qb : ~qb};
			end
		end
		if (z_mark)
		begin
			nxt_st.found = 1'b1;
			// Only the first marker resets in first-marker mode
			if (st_ff.ctrl[CTL_ZERO] && !(st_ff.ctrl[CTL_FIRST] && st_ff.found))
				nxt_st.zarm = 1'b1;
			if (st_ff.ctrl[CTL_ZQ])
				nxt_st.carm = 1'b1;
		end
		if (!st_ff.ctrl[CTL_ZERO])
			nxt_st.zarm = 1'b0;
		if (!st_ff.ctrl[CTL_ZQ])
			nxt_st.carm = 1'b0;
		if (!st_ff.ctrl[CTL_ZQ] && z_rise)
			nxt_st.zcap = st_ff.cnt;
		if (!st_ff.ctrl[CTL_SDIR] && s_rise)
			nxt_st.scap = st_ff.cnt;
		if (st_ff.ctrl[CTL_SDIR] && (st_ff.dir ? s_rise : s_fall))
			nxt_st.scap = st_ff.cnt;

		// Status word
		stat = 16'h0000;
		stat[STS_DIR]   = st_ff.dir;
		stat[STS_UNINI] = st_ff.unini;
		stat[STS_A]     = st_ff.filt[0];
		stat[STS_B]     = st_ff.filt[1];
		stat[STS_Z]     = st_ff.filt[2];
		stat[STS_S]     = st_ff.filt[3];
		stat[STS_FOUND] = st_ff.found;

		// APB slave: answer one cycle into the access phase
		nxt_st.rdy = access;
		nxt_st.err = access & ~mapped(paddr);
		nxt_st.rdat = 32'h0000_0000;
		if (access && !pwrite)
		begin
			unique case (paddr)
				OFS_CONTROL: nxt_st.rdat = {16'h0000, st_ff.ctrl};
				OFS_STATUS:  nxt_st.rdat = {16'h0000, stat};
				OFS_COUNT:   nxt_st.rdat = {16'h0000, st_ff.cnt};
				OFS_MAXCNT:  nxt_st.rdat = {16'h0000, st_ff.maxc};
				OFS_ZCAP:    nxt_st.rdat = {16'h0000, st_ff.zcap};
				OFS_SCAP:    nxt_st.rdat = {16'h0000, st_ff.scap};
				OFS_FILTER:  nxt_st.rdat = {26'h0, st_ff.fdiv};
				default:     nxt_st.rdat = 32'h0000_0000;
			endcase
		end
		if (access && pwrite)
		begin
			unique case (paddr)
				OFS_CONTROL: nxt_st.ctrl = pwdata[15:0];
				OFS_MAXCNT:
				begin
					nxt_st.maxc  = pwdata[15:0];
					nxt_st.unini = 1'b0;
				end
				OFS_FILTER:  nxt_st.fdiv = pwdata[5:0];
				default:     nxt_st.fdiv = st_ff.fdiv;
			endcase
		end
	end

	// ==========================================================
	// State register; captures kept at zero though software must not rely on it
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_ff       <= '0;
			st_ff.ctrl  <= RST_CONTROL;
			st_ff.maxc  <= RST_MAXCNT;
			st_ff.fdiv  <= RST_FILTER;
			st_ff.unini <= 1'b1;
			st_ff.dir   <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign prdata  = st_ff.rdat;
	assign pready  = st_ff.rdy;
	assign pslverr = st_ff.err;

	// ==========================================================
	// Checks
	swap_reset_a: assert property (@(posedge ref_clk) rst |=> st_ff.ctrl == 16'h0000)
		else $error("control not cleared by reset");
	unini_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_ff.unini && !(access && pwrite && paddr == OFS_MAXCNT) |=> st_ff.unini)
		else $error("uninitialised flag dropped early");
	fd_up_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_ff.ctrl[CTL_FDM] && !st_ff.ctrl[CTL_ZERO] && (nf[0] ^ st_ff.filt[0]) && !nf[1] && st_ff.cnt != st_ff.maxc
		|=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
		else $error("pulse mode count up wrong");
	wrap_up_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_ZERO] && pulse && up && st_ff.cnt == st_ff.maxc |=> st_ff.cnt == 16'h0000)
		else $error("no wrap to zero");
	dir_flag_a: assert property (@(posedge ref_clk) disable iff (rst) pulse |=> st_ff.dir == $past(up))
		else $error("direction flag wrong");
	both_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_FDM] && (qa ^ pa) && (qb ^ pb) && !st_ff.zarm |=> $stable(st_ff.cnt))
		else $error("double change counted");
	found_a: assert property (@(posedge ref_clk) disable iff (rst) z_mark |=> st_ff.found)
		else $error("first marker not flagged");
	zcap_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_ZQ] && z_rise |=> st_ff.zcap == $past(st_ff.cnt))
		else $error("index capture missed");
	scap_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_ff.ctrl[CTL_SDIR] && !st_ff.dir && s_fall |=> st_ff.scap == $past(st_ff.cnt))
		else $error("strobe capture missed");
	zero_fwd_a: assert property (@(posedge ref_clk) disable iff (rst) fire && up |=> st_ff.cnt == 16'h0000)
		else $error("index reset value wrong");
	apb_ready_a: assert property (@(posedge ref_clk) disable iff (rst) psel && !penable ##1 psel && penable |=> pready)
		else $error("slave answer late");
	// Reverse index reset lands on the programmed maximum
	rev_max_a: assert property (@(posedge ref_clk) disable iff (rst) fire && !up |=> st_ff.cnt == $past(st_ff.maxc))
		else $error("reverse index reset value wrong");
	// Pin-level decode: A pin edge leaving A and B unequal is forward motion
	quad_up_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_FDM] && !st_ff.ctrl[CTL_SWAP] && (nf[0] ^ st_ff.filt[0]) && !(nf[1] ^ st_ff.filt[1])
		&& (nf[0] != nf[1]) && !st_ff.zarm && st_ff.cnt != st_ff.maxc |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
		else $error("forward quadrature count wrong");
	// Same pin sequence with the swap bit set must count down
	swap_dn_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_FDM] && st_ff.ctrl[CTL_SWAP] && (nf[0] ^ st_ff.filt[0]) && !(nf[1] ^ st_ff.filt[1])
		&& (nf[0] != nf[1]) && !st_ff.zarm && st_ff.cnt != 16'h0000 |=> st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
		else $error("swapped count direction wrong");
	// Qualified index capture takes the count at the pulse after the marker
	zq_cap_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_ff.ctrl[CTL_ZQ] && st_ff.carm && pulse |=> st_ff.zcap == $past(st_ff.cnt))
		else $error("qualified index capture missed");
	// Plain strobe capture on the rising edge
	scap_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st_ff.ctrl[CTL_SDIR] && s_rise |=> st_ff.scap == $past(st_ff.cnt))
		else $error("strobe rise capture missed");
	// Once the first marker is known, first-marker mode never arms again
	first_only_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_ff.ctrl[CTL_FIRST] && st_ff.found && !st_ff.zarm |=> !st_ff.zarm)
		else $error("later marker armed a reset");
	// Bus answer is a single-cycle pulse; an error answer carries zero data
	ready_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) pready |=> !pready)
		else $error("slave answer stretched");
	err_data_a: assert property (@(posedge ref_clk) disable iff (rst) pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer malformed");
	count_c: cover property (@(posedge ref_clk) disable iff (rst) pulse && up ##1 pulse && !up);
	fd_c: cover property (@(posedge ref_clk) disable iff (rst) st_ff.ctrl[CTL_FDM] && pulse && !up);
	swap_c: cover property (@(posedge ref_clk) disable iff (rst) st_ff.ctrl[CTL_SWAP] && pulse && !up);
	reset_c: cover property (@(posedge ref_clk) disable iff (rst) fire);
	first_c: cover property (@(posedge ref_clk) disable iff (rst) st_ff.ctrl[CTL_FIRST] && z_mark && st_ff.found);

endmodule

// [src/qec_pkg.sv]
// Package with register map, field positions and reset values of the encoder counter
package qec_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_COUNT   = 8'h08;
	localparam logic [7:0] OFS_MAXCNT  = 8'h0c;
	localparam logic [7:0] OFS_ZCAP    = 8'h10;
	localparam logic [7:0] OFS_SCAP    = 8'h14;
	localparam logic [7:0] OFS_FILTER  = 8'h18;

	// ==========================================================
	// Control field positions
	localparam int CTL_SWAP  = 0;
	localparam int CTL_ZERO  = 1;
	localparam int CTL_FIRST = 2;
	localparam int CTL_FDM   = 6;
	localparam int CTL_ZQ    = 7;
	localparam int CTL_SDIR  = 8;

	// Status field positions
	localparam int STS_DIR   = 1;
	localparam int STS_UNINI = 2;
	localparam int STS_A     = 3;
	localparam int STS_B     = 4;
	localparam int STS_Z     = 5;
	localparam int STS_S     = 6;
	localparam int STS_FOUND = 7;

	// ==========================================================
	// Reset values and counts
	localparam logic [15:0] RST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_MAXCNT  = 16'hffff;
	localparam logic [5:0]  RST_FILTER  = 6'h00;
	localparam logic [1:0]  FILT_STABLE = 2'h2;  // Four equal samples

endpackage

// [verification/qec_encoder_model.sv]
// Encoder partner: quadrature, pulse/direction and marker pins
`timescale 1ns/1ps
// ==========================================
// Shaft encoder model
module qec_encoder_model
(
	input  wire logic ref_clk,
	output logic      phase_a_pin,
	output logic      phase_b_pin,
	output logic      index_marker_pin,
	output logic      strobe_marker_pin
);
	int ph = 0;

	// Pins start low so the counter sees a defined state
	initial {phase_a_pin, phase_b_pin, index_marker_pin, strobe_marker_pin} = 4'h0;

	// Each level stands 11 clocks, longer than sync plus filter delay
	task automatic hold(input logic [3:0] v);
		@(posedge ref_clk);
		{phase_a_pin, phase_b_pin, index_marker_pin, strobe_marker_pin} <= v;
		repeat (10) @(posedge ref_clk);
	endtask

	// Gray sequence, one pin at a time; A leads B when moving up
	task automatic quad(input bit up, input int n);
		repeat (n)
		begin
			ph = (ph + (up ? 1 : 3)) % 4;
			hold({(ph == 1 || ph == 2), (ph == 2 || ph == 3), index_marker_pin, strobe_marker_pin});
		end
	endtask

	// Even edge count so A returns; B restored for quadrature use later
	task automatic fd(input bit dn, input int n);
		logic b0;
		b0 = phase_b_pin;
		hold({phase_a_pin, dn, index_marker_pin, strobe_marker_pin});
		repeat (2 * n) hold({~phase_a_pin, dn, index_marker_pin, strobe_marker_pin});
		hold({phase_a_pin, b0, index_marker_pin, strobe_marker_pin});
	endtask

	// Marker levels only, encoder phases held
	task automatic mark(input bit z, input bit s);
		hold({phase_a_pin, phase_b_pin, z, s});
	endtask
endmodule

// [verification/quadrature_encoder_counter_bench.sv]
// Self-checking bench for the encoder position counter
`timescale 1ns/1ps
// ==========================================
// Bench top
module quadrature_encoder_counter_bench
	import qec_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er;
	logic        pa, pb, pz, ps;
	int          mismatches = 0;
	int          check_count = 0;
	int          cnt = 0;
	int          mx = 0;
	int          sc = 0;
	bit          swp = 0;

	qec_counter qec_counter_inst (.ref_clk(ref_clk), .rst(rst), .phase_a_pin(pa), .phase_b_pin(pb),
		.index_marker_pin(pz), .strobe_marker_pin(ps), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	qec_encoder_model qec_encoder_model_inst (.ref_clk(ref_clk), .phase_a_pin(pa), .phase_b_pin(pb),
		.index_marker_pin(pz), .strobe_marker_pin(ps));

	// 25 MHz clock
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input bit w, input logic [7:0] ad, input logic [31:0] d);
		int t;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge ref_clk);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		// A missing answer is a failure, not a silent exit
		if (pready !== 1'b1)
			mismatches++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [31:0] m, input int e);
		apb(1'b0, ad, 32'h0);
		chk(rd & m, 32'(e));
	endtask

	// Reference counter with wrap at the programmed maximum
	function automatic void step(input bit up);
		cnt = up ? (cnt == mx ? 0 : cnt + 1) : (cnt == 0 ? mx : cnt - 1);
	endfunction

	task automatic q(input bit up, input int n);
		qec_encoder_model_inst.quad(up, n);
		repeat (n) step(up ^ swp);
	endtask

	task automatic f(input bit dn, input int n);
		qec_encoder_model_inst.fd(dn, n);
		repeat (2 * n) step(~dn);
	endtask

	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard, far beyond the thousand or so clocks the tests need
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		give_verdict();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hca27));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(OFS_CONTROL, 32'hffffffff, 0);
		rchk(OFS_STATUS, 32'h86, 32'h06);
		apb(1'b1, OFS_MAXCNT, 32'h000b);
		mx = 11;
		rchk(OFS_STATUS, 32'h04, 0);
		q(1, 5 + $urandom % 20);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		rchk(OFS_STATUS, 32'h02, 32'h02);
		q(0, 5 + $urandom % 20);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		rchk(OFS_STATUS, 32'h02, 0);
		apb(1'b1, OFS_COUNT, 32'h5);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		apb(1'b1, OFS_CONTROL, 32'h1);
		swp = 1;
		q(1, 3);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		// Pulse/direction with marker modes left clear
		apb(1'b1, OFS_CONTROL, 32'h40);
		swp = 0;
		f(0, 1 + $urandom % 4);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		f(1, 5);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		// Plain captures on rising marker edges
		apb(1'b1, OFS_CONTROL, 32'h0);
		qec_encoder_model_inst.mark(1, 0);
		rchk(OFS_ZCAP, 32'hffffffff, cnt);
		qec_encoder_model_inst.mark(0, 1);
		sc = cnt;
		rchk(OFS_SCAP, 32'hffffffff, sc);
		qec_encoder_model_inst.mark(0, 0);
		// Counting down: only the falling strobe edge captures
		apb(1'b1, OFS_CONTROL, 32'h100);
		q(0, 2);
		qec_encoder_model_inst.mark(0, 1);
		q(0, 1);
		rchk(OFS_SCAP, 32'hffffffff, sc);
		qec_encoder_model_inst.mark(0, 0);
		sc = cnt;
		rchk(OFS_SCAP, 32'hffffffff, sc);
		// Index reset fires on the pulse after the marker, not at it
		apb(1'b1, OFS_CONTROL, 32'h2);
		q(1, 1);
		qec_encoder_model_inst.mark(1, 0);
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		qec_encoder_model_inst.quad(1, 1);
		cnt = 0;
		rchk(OFS_COUNT, 32'hffffffff, cnt);
		rchk(OFS_STATUS, 32'h80, 32'h80);
		// Unmapped address answers with an error and zero data
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule
